// File: trhp_pkg.sv
// Package of constants and types for the touch report host port
// Overview of operation
// RULE1: Variant and strap select I2C, SPI or UART
// RULE2: I2C target answers bus address 0x9A only
// RULE3: I2C mode: SDO high while data waits
// RULE4: SPI target, SCK idles low, falling-edge output
// RULE5: SPI mode: interrupt pin high with data
// RULE6: SPI target select is active low
// RULE7: SPI with nothing pending returns 0x4D
// RULE8: UART runs fixed at 9600 baud
// RULE9: Non-SPI LED: slow blink idle, flicker touching
// RULE10: SPI LED: off idle, flicker while touching
// RULE11: Each touch result is exactly five bytes
// RULE12: Coordinates are unsigned 12-bit, 0 to 4095
// RULE13: Uncalibrated: two coordinate LSBs forced zero
// RULE14: Byte one: bit7 set, reserved zero, pen
// RULE15: Bytes two to five carry coordinate halves
// RULE16: Host should use the full 12-bit fields
// RULE17: Interrupt drops once packets drained, none queued
// RULE18: UART character 8N1, LSB first
package trhp_pkg;
    localparam int COORD_W = 12;
    localparam int PKT_BYTES = 5;
    localparam logic [2:0] PKT_LAST_IDX = 3'h4;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 32;
    localparam logic [7:0] I2C_ADDR_BYTE = 8'h9A;
    localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
    localparam logic [7:0] FILLER_BYTE = 8'h4D;
    localparam logic [7:0] HDR_MARK = 8'h80;
    localparam int CLK_HZ = 250_000_000;
    localparam int UART_BAUD = 9600;
    localparam int UART_DIV = CLK_HZ / UART_BAUD;
    localparam logic [3:0] UART_LAST_BIT = 4'h9;
    localparam int LED_SLOW_BIT = 25;
    localparam int LED_FAST_BIT = 10;

    typedef enum logic [1:0] {
        MODE_I2C = 2'b00,
        MODE_SPI = 2'b01,
        MODE_UART = 2'b10
    } trhp_mode_t;

    typedef enum logic [2:0] {
        I2C_IDLE = 3'b000,
        I2C_ADDR = 3'b001,
        I2C_AACK = 3'b010,
        I2C_TX = 3'b011,
        I2C_TACK = 3'b100,
        I2C_RX = 3'b101,
        I2C_RACK = 3'b110
    } trhp_i2c_st_t;

    typedef struct packed {
        logic pen;
        logic [COORD_W-1:0] horizontal_coordinate;
        logic [COORD_W-1:0] vertical_coordinate;
    } trhp_touch_t;
endpackage

// File: trhp_top.sv
// Touch report host port: packet framer, byte FIFO and I2C/SPI/UART target ends
`timescale 1ns/1ps
`default_nettype none

module trhp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    wire push = wr_valid_in && wr_ready_out;
    wire pop = rd_valid_out && rd_ready_in;

    // Pointers wrap by width alone, so the depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("trhp_fifo: DEPTH must be a power of two");
    end

    // Full and empty come straight from the occupancy count
    assign wr_ready_out = count_reg != (AW+1)'(DEPTH);
    assign rd_valid_out = count_reg != '0;
    assign rd_data_out = mem_reg[rd_ptr_reg];

    // Storage has no reset; the occupancy count alone says what is valid
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= wr_data_in;
        end
    end

    // Pointer and occupancy update
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + AW'(push);
            rd_ptr_reg <= rd_ptr_reg + AW'(pop);
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module trhp_top import trhp_pkg::*; #(
    parameter int UART_DIV_P = UART_DIV,
    parameter int LED_SLOW_P = LED_SLOW_BIT,
    parameter int LED_FAST_P = LED_FAST_BIT
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic link_sck_in,
    input wire logic spi_select_n_in,
    input wire logic variant_uart_in,
    input wire logic host_interface_select_strap_in,
    input wire logic calibrated_in,
    input wire trhp_touch_t touch_in,
    input wire logic touch_valid_in,
    output logic touch_ready_out,
    input wire logic scl_tx_in,
    output logic scl_tx_out,
    output logic scl_tx_oe_out,
    input wire logic sda_rx_in,
    output logic sda_rx_out,
    output logic sda_rx_oe_out,
    output logic sdo_out,
    output logic irq_and_led_output_out,
    output trhp_mode_t mode_out
);
    localparam int DIV_W = $clog2(UART_DIV_P);

    if (UART_DIV_P < 2 || LED_FAST_P >= LED_SLOW_P) begin : g_param_check
        $error("trhp_top: UART divider below 2 or LED bits out of order");
    end

    // Mode selection
    logic [1:0] strap_s1_reg;
    logic [1:0] strap_s2_reg;
    logic mode_set_reg;
    trhp_mode_t mode_reg;
    // Framer
    trhp_touch_t pkt_reg;
    logic [2:0] idx_reg;
    logic busy_reg;
    logic pen_reg;
    // FIFO
    logic [7:0] fifo_rd_data;
    logic fifo_rd_valid;
    logic fifo_wr_ready;
    // SPI hand-over, clock side
    logic [7:0] hold_reg;
    logic offer_reg;
    logic ack_s1_reg;
    logic ack_s2_reg;
    // SPI, link side
    logic offer_s1_reg;
    logic offer_s2_reg;
    logic ack_reg;
    logic [2:0] spi_cnt_reg;
    logic [7:0] spi_sh_reg;
    logic spi_out_reg;
    // I2C
    logic scl_s1_reg;
    logic scl_s2_reg;
    logic scl_d_reg;
    logic sda_s1_reg;
    logic sda_s2_reg;
    logic sda_d_reg;
    trhp_i2c_st_t i2c_st_reg;
    trhp_i2c_st_t i2c_st_next;
    logic [3:0] i2c_cnt_reg;
    logic [3:0] i2c_cnt_next;
    logic [7:0] i2c_sh_reg;
    logic [7:0] i2c_sh_next;
    logic i2c_rd_reg;
    logic i2c_rd_next;
    logic i2c_ack_reg;
    logic i2c_ack_next;
    logic i2c_oe_reg;
    logic i2c_oe_next;
    logic i2c_load;
    // UART
    logic [DIV_W-1:0] uart_div_reg;
    logic [3:0] uart_bit_reg;
    logic [9:0] uart_frame_reg;
    logic uart_busy_reg;
    // Status
    logic [LED_SLOW_P:0] led_cnt_reg;
    logic irq_reg;
    logic pin_reg;

    // Strap and variant are static pins; both pass a synchroniser first
    always_ff @(posedge clk_in) begin
        strap_s1_reg <= {variant_uart_in, host_interface_select_strap_in};
        strap_s2_reg <= strap_s1_reg;
    end

    wire trhp_mode_t mode_pick = strap_s2_reg[1] ? MODE_UART : // [RULE1]
        (strap_s2_reg[0] ? MODE_SPI : MODE_I2C);
    wire is_i2c = mode_reg == MODE_I2C;
    wire is_spi = mode_reg == MODE_SPI;
    wire is_uart = mode_reg == MODE_UART;

    // Interface is caught once after reset and then frozen
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mode_set_reg <= 1'b0;
            mode_reg <= MODE_I2C;
        end else if (!mode_set_reg) begin
            mode_set_reg <= 1'b1;
            mode_reg <= mode_pick; // [RULE1]
        end
    end

    // Framer: capture one result, then stream its five bytes into the FIFO
    wire [COORD_W-1:0] x_in = touch_in.horizontal_coordinate;
    wire [COORD_W-1:0] y_in = touch_in.vertical_coordinate;
    wire [COORD_W-1:0] x_cap = calibrated_in ? x_in : {x_in[11:2], 2'b00}; // [RULE13]
    wire [COORD_W-1:0] y_cap = calibrated_in ? y_in : {y_in[11:2], 2'b00}; // [RULE13]
    wire [COORD_W-1:0] x_pk = pkt_reg.horizontal_coordinate;
    wire [COORD_W-1:0] y_pk = pkt_reg.vertical_coordinate;
    wire take = touch_valid_in && touch_ready_out;
    wire push = busy_reg && fifo_wr_ready;
    wire [7:0] pkt_byte = (idx_reg == 3'h0) ? (HDR_MARK | {7'h00, pkt_reg.pen}) : // [RULE14]
        (idx_reg == 3'h1) ? {1'b0, x_pk[6:0]} : // [RULE15]
        (idx_reg == 3'h2) ? {3'b000, x_pk[11:7]} : // [RULE15]
        (idx_reg == 3'h3) ? {1'b0, y_pk[6:0]} : {3'b000, y_pk[11:7]}; // [RULE15] [RULE12]
    assign touch_ready_out = !busy_reg;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pkt_reg <= '0;
            pen_reg <= 1'b0;
            busy_reg <= 1'b0;
            idx_reg <= '0;
        end else if (take) begin
            pkt_reg <= '{touch_in.pen, x_cap, y_cap};
            pen_reg <= touch_in.pen;
            busy_reg <= 1'b1;
            idx_reg <= '0;
        end else if (push) begin
            busy_reg <= idx_reg != PKT_LAST_IDX; // [RULE11]
            idx_reg <= (idx_reg == PKT_LAST_IDX) ? 3'h0 : idx_reg + 3'h1;
        end
    end

    // Three ends compete for the FIFO head; the mode lets only one ask
    wire spi_load = is_spi && (offer_reg == ack_s2_reg) && fifo_rd_valid;
    wire uart_start = is_uart && !uart_busy_reg && fifo_rd_valid;
    wire fifo_pop = spi_load || uart_start || (i2c_load && fifo_rd_valid);
    wire [7:0] tx_byte = fifo_rd_valid ? fifo_rd_data : FILLER_BYTE;

    trhp_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .wr_data_in(pkt_byte),
        .wr_valid_in(busy_reg),
        .wr_ready_out(fifo_wr_ready),
        .rd_data_out(fifo_rd_data),
        .rd_valid_out(fifo_rd_valid),
        .rd_ready_in(fifo_pop)
    );

    // SPI hand-over: hold_reg stays still while offer and ack differ
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            offer_reg <= 1'b0;
            hold_reg <= '0;
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end else begin
            ack_s1_reg <= ack_reg;
            ack_s2_reg <= ack_s1_reg;
            if (spi_load) begin
                offer_reg <= ~offer_reg;
                hold_reg <= fifo_rd_data;
            end
        end
    end

    // Link side; deselect or another mode holds the byte counter cleared
    wire spi_rst = reset_in || spi_select_n_in || !is_spi; // [RULE6]
    wire spi_avail = offer_s2_reg != ack_reg;
    wire [7:0] spi_cur = spi_avail ? hold_reg : FILLER_BYTE; // [RULE7]

    // Byte boundary: first rising edge freezes the byte to send
    always_ff @(posedge link_sck_in or posedge spi_rst) begin
        if (spi_rst) begin
            spi_cnt_reg <= '0;
            spi_sh_reg <= '0;
        end else begin
            spi_cnt_reg <= spi_cnt_reg + 3'h1;
            if (spi_cnt_reg == 3'h0) begin
                spi_sh_reg <= spi_cur;
            end
        end
    end

    // Offer sync shares the ack reset, so no stale offer survives a reset; ack only a byte taken
    always_ff @(posedge link_sck_in or posedge reset_in) begin
        if (reset_in) begin
            offer_s1_reg <= 1'b0;
            offer_s2_reg <= 1'b0;
            ack_reg <= 1'b0;
        end else begin
            offer_s1_reg <= offer_reg;
            offer_s2_reg <= offer_s1_reg;
            if (!spi_rst && spi_cnt_reg == 3'h0 && spi_avail) begin
                ack_reg <= ~ack_reg;
            end
        end
    end

    // Output bits change on the falling edge, MSB first
    always_ff @(negedge link_sck_in or posedge spi_rst) begin
        if (spi_rst) begin
            spi_out_reg <= 1'b0;
        end else begin
            spi_out_reg <= spi_sh_reg[3'h7 - spi_cnt_reg]; // [RULE4]
        end
    end

    // I2C lines are oversampled; the third stage only serves edge detection
    always_ff @(posedge clk_in) begin
        scl_s1_reg <= scl_tx_in;
        scl_s2_reg <= scl_s1_reg;
        scl_d_reg <= scl_s2_reg;
        sda_s1_reg <= sda_rx_in;
        sda_s2_reg <= sda_s1_reg;
        sda_d_reg <= sda_s2_reg;
    end

    wire scl_rise = scl_s2_reg && !scl_d_reg;
    wire scl_fall = !scl_s2_reg && scl_d_reg;
    wire scl_high = scl_s2_reg && scl_d_reg;
    wire i2c_start = scl_high && sda_d_reg && !sda_s2_reg;
    wire i2c_stop = scl_high && !sda_d_reg && sda_s2_reg;
    wire addr_hit = i2c_sh_reg[7:1] == I2C_ADDR_BYTE[7:1]; // [RULE2]

    // Target-only state machine; writes are acknowledged and dropped
    always_comb begin
        i2c_st_next = i2c_st_reg;
        i2c_cnt_next = i2c_cnt_reg;
        i2c_sh_next = i2c_sh_reg;
        i2c_rd_next = i2c_rd_reg;
        i2c_ack_next = i2c_ack_reg;
        i2c_oe_next = i2c_oe_reg;
        i2c_load = 1'b0;
        if (!is_i2c || i2c_stop) begin
            i2c_st_next = I2C_IDLE;
            i2c_oe_next = 1'b0;
        end else if (i2c_start) begin
            i2c_st_next = I2C_ADDR;
            i2c_cnt_next = '0;
            i2c_oe_next = 1'b0;
        end else begin
            unique case (i2c_st_reg)
                I2C_IDLE: begin
                    i2c_oe_next = 1'b0;
                end
                I2C_ADDR, I2C_RX: begin
                    if (scl_rise) begin
                        i2c_sh_next = {i2c_sh_reg[6:0], sda_s2_reg};
                        i2c_cnt_next = i2c_cnt_reg + 4'h1;
                    end else if (scl_fall && i2c_cnt_reg == I2C_BYTE_BITS) begin
                        if (i2c_st_reg == I2C_ADDR && !addr_hit) begin
                            i2c_st_next = I2C_IDLE; // [RULE2]
                        end else begin
                            i2c_st_next = (i2c_st_reg == I2C_ADDR) ? I2C_AACK : I2C_RACK;
                            i2c_oe_next = 1'b1;
                            if (i2c_st_reg == I2C_ADDR) begin
                                i2c_rd_next = i2c_sh_reg[0];
                            end
                        end
                    end
                end
                I2C_AACK, I2C_RACK: begin
                    if (scl_fall) begin
                        i2c_cnt_next = '0;
                        i2c_oe_next = 1'b0;
                        i2c_st_next = I2C_RX;
                        if (i2c_st_reg == I2C_AACK && i2c_rd_reg) begin
                            i2c_load = 1'b1;
                            i2c_sh_next = tx_byte;
                            i2c_oe_next = !tx_byte[7];
                            i2c_st_next = I2C_TX;
                        end
                    end
                end
                I2C_TX: begin
                    if (scl_rise) begin
                        i2c_cnt_next = i2c_cnt_reg + 4'h1;
                    end else if (scl_fall && i2c_cnt_reg == I2C_BYTE_BITS) begin
                        i2c_oe_next = 1'b0;
                        i2c_st_next = I2C_TACK;
                    end else if (scl_fall) begin
                        i2c_sh_next = {i2c_sh_reg[6:0], 1'b0};
                        i2c_oe_next = !i2c_sh_reg[6];
                    end
                end
                I2C_TACK: begin
                    if (scl_rise) begin
                        i2c_ack_next = !sda_s2_reg;
                    end else if (scl_fall && i2c_ack_reg) begin
                        i2c_load = 1'b1;
                        i2c_sh_next = tx_byte;
                        i2c_oe_next = !tx_byte[7];
                        i2c_cnt_next = '0;
                        i2c_st_next = I2C_TX;
                    end else if (scl_fall) begin
                        i2c_st_next = I2C_IDLE;
                    end
                end
                default: begin
                    i2c_st_next = I2C_IDLE;
                    i2c_oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            i2c_st_reg <= I2C_IDLE;
            i2c_cnt_reg <= '0;
            i2c_sh_reg <= '0;
            i2c_rd_reg <= 1'b0;
            i2c_ack_reg <= 1'b0;
            i2c_oe_reg <= 1'b0;
        end else begin
            i2c_st_reg <= i2c_st_next;
            i2c_cnt_reg <= i2c_cnt_next;
            i2c_sh_reg <= i2c_sh_next;
            i2c_rd_reg <= i2c_rd_next;
            i2c_ack_reg <= i2c_ack_next;
            i2c_oe_reg <= i2c_oe_next;
        end
    end

    // UART transmitter: start, eight data bits LSB first, stop
    wire uart_tick = uart_div_reg == '0;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            uart_busy_reg <= 1'b0;
            uart_frame_reg <= '1;
            uart_div_reg <= '0;
            uart_bit_reg <= '0;
        end else if (uart_start) begin
            uart_busy_reg <= 1'b1;
            uart_frame_reg <= {1'b1, fifo_rd_data, 1'b0}; // [RULE18]
            uart_div_reg <= DIV_W'(UART_DIV_P - 1); // [RULE8]
            uart_bit_reg <= '0;
        end else if (uart_busy_reg && uart_tick) begin
            uart_frame_reg <= {1'b1, uart_frame_reg[9:1]};
            uart_div_reg <= DIV_W'(UART_DIV_P - 1); // [RULE8]
            uart_bit_reg <= uart_bit_reg + 4'h1;
            uart_busy_reg <= uart_bit_reg != UART_LAST_BIT; // [RULE18]
        end else if (uart_busy_reg) begin
            uart_div_reg <= uart_div_reg - DIV_W'(1);
        end
    end

    // Interrupt covers queued bytes, a packet in framing and a held SPI byte
    wire irq_next = fifo_rd_valid || busy_reg || (offer_reg != ack_s2_reg); // [RULE17]
    wire led_next = pen_reg ? led_cnt_reg[LED_FAST_P] : // [RULE9] [RULE10]
        (!is_spi && led_cnt_reg[LED_SLOW_P]);

    // Shared pin: in SPI mode data-ready wins over the LED pattern
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            led_cnt_reg <= '0;
            irq_reg <= 1'b0;
            pin_reg <= 1'b0;
        end else begin
            led_cnt_reg <= led_cnt_reg + (LED_SLOW_P+1)'(1);
            irq_reg <= irq_next;
            pin_reg <= is_spi ? (irq_next || led_next) : led_next; // [RULE5]
        end
    end

    // Pin drive per mode; the I2C end never stretches SCL
    assign sdo_out = is_spi ? ((spi_cnt_reg == 3'h0) ? spi_cur[7] : spi_out_reg) : // [RULE4]
        (is_i2c && irq_reg); // [RULE3]
    assign scl_tx_out = uart_frame_reg[0];
    assign scl_tx_oe_out = is_uart;
    assign sda_rx_out = 1'b0;
    assign sda_rx_oe_out = is_i2c && i2c_oe_reg;
    assign irq_and_led_output_out = pin_reg;
    assign mode_out = mode_reg;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    sequence s_last_push;
        push && idx_reg == PKT_LAST_IDX;
    endsequence

    AST_MODE_FROZEN: assert property (mode_set_reg |=> $stable(mode_reg)) // [RULE1]
        else $error("interface mode changed after selection");
    AST_I2C_NACK_ADDR: assert property (is_i2c && i2c_st_reg == I2C_ADDR && scl_fall && // [RULE2]
        i2c_cnt_reg == I2C_BYTE_BITS && !addr_hit && !i2c_stop && !i2c_start |=> !i2c_oe_reg)
        else $error("foreign I2C address acknowledged");
    AST_I2C_IRQ: assert property (is_i2c && fifo_rd_valid |=> ##1 sdo_out) // [RULE3]
        else $error("I2C interrupt missing with data pending");
    AST_SPI_IRQ: assert property (is_spi && fifo_rd_valid |=> ##1 irq_and_led_output_out) // [RULE5]
        else $error("SPI interrupt missing with data pending");
    AST_HEADER: assert property (push && idx_reg == 3'h0 |-> pkt_byte[7] && pkt_byte[6:1] == 6'h00) // [RULE14]
        else $error("header byte malformed");
    AST_COORD_BYTES: assert property (push && idx_reg != 3'h0 |-> !pkt_byte[7] && // [RULE15]
        (idx_reg[0] || pkt_byte[6:5] == 2'b00))
        else $error("coordinate byte has upper bits set");
    AST_UNCAL: assert property (take && !calibrated_in |=> x_pk[1:0] == 2'b00 && y_pk[1:0] == 2'b00) // [RULE13]
        else $error("uncalibrated low bits not cleared");
    AST_FIVE: assert property (take |=> busy_reg [*5]) // [RULE11]
        else $error("packet not five bytes");
    AST_FIVE_END: assert property (s_last_push |=> !busy_reg) // [RULE11]
        else $error("framing ran past five bytes");
    AST_UART_START: assert property (uart_start |=> !scl_tx_out [*8]) // [RULE18]
        else $error("UART start bit not low");
    AST_IRQ_DROP: assert property ($fell(irq_reg) |-> !$past(fifo_rd_valid) && !$past(busy_reg)) // [RULE17]
        else $error("interrupt dropped with data queued");
    AST_SPI_FILLER: assert property (@(posedge link_sck_in) disable iff (spi_rst) // [RULE7]
        spi_cnt_reg == 3'h0 && !spi_avail |=> spi_sh_reg == FILLER_BYTE)
        else $error("SPI filler byte wrong");
endmodule

`default_nettype wire

// File: trhp_spi_host.sv
// Host-side SPI controller model that clocks report bytes out of the port
`timescale 1ns/1ps
`default_nettype none
module trhp_spi_host (
    output logic sck_out,
    output logic select_n_out,
    input wire logic sdo_in
);
    // Idle: clock parked low, target deselected
    initial begin
        sck_out = 1'b0;
        select_n_out = 1'b1;
    end
    // Select held low across the whole frame; odd offset keeps it off the system clock phase
    task automatic open_frame();
        #31.3 select_n_out = 1'b0;
        #30;
    endtask
    task automatic close_frame();
        #30 select_n_out = 1'b1;
    endtask
    // Sample just before each rise, since the target moves its data on falls
    task automatic get_byte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #24 b[i] = sdo_in;
            sck_out = 1'b1;
            #24 sck_out = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// File: test_touch_report_host_port.sv
// Self-checking bench for the touch report host port
`timescale 1ns/1ps
`default_nettype none
module test_touch_report_host_port import trhp_pkg::*;;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic variant_uart_in = 1'b0;
    logic strap_in = 1'b1;
    logic calibrated_in = 1'b0;
    trhp_touch_t touch_in = '0;
    logic touch_valid_in = 1'b0;
    logic touch_ready_out, scl_tx_out, scl_tx_oe_out, sdo_out, irq_out, sda_oe;
    logic scl = 1'b1;
    logic sda = 1'b1;
    trhp_mode_t mode_out;
    wire sck, sel_n;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;
    logic [39:0] exp_q[$];

    always #2 clk_in = ~clk_in;

    // Short divisors keep UART characters and LED periods brief in simulation
    trhp_top #(.UART_DIV_P(8), .LED_SLOW_P(6), .LED_FAST_P(2)) dut (
        .clk_in(clk_in), .reset_in(reset_in), .link_sck_in(sck), .spi_select_n_in(sel_n),
        .variant_uart_in(variant_uart_in), .host_interface_select_strap_in(strap_in),
        .calibrated_in(calibrated_in), .touch_in(touch_in), .touch_valid_in(touch_valid_in),
        .touch_ready_out(touch_ready_out), .scl_tx_in(scl), .scl_tx_out(scl_tx_out),
        .scl_tx_oe_out(scl_tx_oe_out), .sda_rx_in(sda), .sda_rx_out(), .sda_rx_oe_out(sda_oe),
        .sdo_out(sdo_out), .irq_and_led_output_out(irq_out), .mode_out(mode_out));

    trhp_spi_host host (.sck_out(sck), .select_n_out(sel_n), .sdo_in(sdo_out));

    // Expected five-byte report for one touch result
    function automatic logic [39:0] pkt(trhp_touch_t t, logic cal);
        logic [11:0] x;
        logic [11:0] y;
        x = cal ? t.horizontal_coordinate : (t.horizontal_coordinate & 12'hFFC);
        y = cal ? t.vertical_coordinate : (t.vertical_coordinate & 12'hFFC);
        return {7'h40, t.pen, 1'b0, x[6:0], 3'h0, x[11:7], 1'b0, y[6:0], 3'h0, y[11:7]};
    endfunction

    task automatic chk(string what, logic [39:0] exp, logic [39:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Straps only count at reset, so each mode gets its own reset
    task automatic do_reset(logic var_u, logic strap);
        @(posedge clk_in);
        reset_in <= 1'b1;
        variant_uart_in <= var_u;
        strap_in <= strap;
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        exp_q.delete();
    endtask

    // Valid held until ready is seen high at a sampling edge
    task automatic send(trhp_touch_t t, logic cal);
        int n;
        n = 0;
        @(posedge clk_in);
        touch_in <= t;
        calibrated_in <= cal;
        touch_valid_in <= 1'b1;
        @(negedge clk_in);
        while (touch_ready_out !== 1'b1 && n < 200) begin
            @(negedge clk_in);
            n++;
        end
        @(posedge clk_in);
        touch_valid_in <= 1'b0;
        exp_q.push_back(pkt(t, cal));
    endtask

    task automatic count_high(output int c);
        c = 0;
        repeat (256) begin
            @(negedge clk_in);
            c += (irq_out === 1'b1);
        end
    endtask

    // Filler bytes have bit 7 clear, so skip until a header shows up
    task automatic read_pkt(output logic [39:0] p);
        logic [7:0] b;
        int n;
        n = 0;
        b = 8'h00;
        host.open_frame();
        while (b[7] !== 1'b1 && n < 40) begin
            host.get_byte(b);
            n++;
        end
        p[39:32] = b;
        for (int i = 3; i >= 0; i--) begin
            host.get_byte(b);
            p[i*8 +: 8] = b;
        end
        host.close_frame();
    endtask

    // Mid-bit sampling of one character at eight cycles a bit
    task automatic uart_rx(output logic [7:0] b);
        int n;
        n = 0;
        b = 8'h00;
        while (scl_tx_out !== 1'b0 && n < 2000) begin
            @(negedge clk_in);
            n++;
        end
        repeat (4) @(negedge clk_in);
        chk("uart start", 40'h0, {39'h0, scl_tx_out});
        for (int i = 0; i < 8; i++) begin
            repeat (8) @(negedge clk_in);
            b[i] = scl_tx_out;
        end
        repeat (8) @(negedge clk_in);
        chk("uart stop", 40'h1, {39'h0, scl_tx_out});
    endtask

    // Start, then eight address bits and a released ninth
    task automatic i2c_addr(logic [8:0] a);
        repeat (8) @(posedge clk_in);
        sda <= 1'b0;
        for (int i = 8; i >= 0; i--) begin
            repeat (8) @(posedge clk_in);
            scl <= 1'b0;
            sda <= a[i];
            repeat (8) @(posedge clk_in);
            scl <= 1'b1;
        end
        repeat (8) @(posedge clk_in);
    endtask

    // Hang guard well above the expected run length
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 32'h0000_9C40) begin
            err_count++;
            wrap_up();
        end
    end

    initial begin
        logic [39:0] p;
        logic [7:0] b;
        trhp_touch_t t;
        int c;
        c = $urandom(71984);
        do_reset(1'b0, 1'b0);
        chk("mode", 40'(MODE_I2C), 40'(mode_out));
        count_high(c);
        chk("slow blink", 40'h80, 40'(c));
        send(25'h0ABC123, 1'b1);
        repeat (8) @(negedge clk_in);
        chk("i2c irq", 40'h1, {39'h0, sdo_out});
        i2c_addr({I2C_ADDR_BYTE, 1'b1});
        chk("i2c ack", 40'h1, {39'h0, sda_oe});
        i2c_addr({8'h9C, 1'b1});
        chk("i2c foreign", 40'h0, {39'h0, sda_oe});
        $display("test i2c done");
        do_reset(1'b0, 1'b1);
        chk("mode", 40'(MODE_SPI), 40'(mode_out));
        count_high(c);
        chk("led idle", 40'h0, 40'(c));
        host.open_frame();
        host.get_byte(b);
        host.close_frame();
        chk("filler", 40'(FILLER_BYTE), 40'(b));
        send(25'h0FFFFFF, 1'b0);
        repeat (3) @(negedge clk_in);
        chk("irq", 40'h1, {39'h0, irq_out});
        read_pkt(p);
        chk("packet", exp_q.pop_front(), p);
        repeat (12) @(negedge clk_in);
        chk("irq drop", 40'h0, {39'h0, irq_out});
        // Seven reports overrun the buffer, so framing must stall
        for (int k = 0; k < 7; k++) begin
            t = 25'($urandom);
            t.pen = (k == 6) ? 1'b1 : t.pen;
            send(t, 1'(k % 2));
        end
        repeat (40) @(negedge clk_in);
        chk("full stall", 40'h0, {39'h0, touch_ready_out});
        while (exp_q.size() > 0) begin
            read_pkt(p);
            chk("packet", exp_q.pop_front(), p);
        end
        repeat (12) @(negedge clk_in);
        count_high(c);
        chk("flicker", 40'h80, 40'(c));
        $display("test spi done");
        do_reset(1'b1, 1'b1);
        chk("mode", 40'(MODE_UART), 40'(mode_out));
        send(25'($urandom), 1'b1);
        for (int i = 4; i >= 0; i--) begin
            uart_rx(b);
            p[i*8 +: 8] = b;
        end
        chk("uart packet", exp_q.pop_front(), p);
        chk("tx enable", 40'h1, {39'h0, scl_tx_oe_out});
        $display("test uart done");
        wrap_up();
    end
endmodule
`default_nettype wire
